// *** tb/uac_remote_node.sv ***
// Remote serial node model: drives the receive line and the baud tick
`timescale 1ns/1ns
module uac_remote_node (
	input wire logic clk_i,
	output logic rxd_o,
	output logic tick_o
);
	int tick_period = 16;
	int tick_cnt = 0;
	initial begin
		rxd_o = 1'b1;
		tick_o = 1'b0;
	end
	// Free running baud tick, one cycle wide
	always @(posedge clk_i) begin
		tick_cnt <= (tick_cnt >= tick_period - 1) ? 0 : tick_cnt + 1;
		tick_o <= (tick_cnt == 0);
	end
	// Start bit, data lsb first, stop bit; line rests high after the stop bit
	task automatic send_byte(input logic [7:0] data, input int period);
		logic [9:0] frame;
		frame = {1'b1, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= frame[i];
			repeat (period) @(posedge clk_i);
		end
	endtask : send_byte
	// Line held low far longer than any frame, then released high
	task automatic hold_low(input int cycles);
		rxd_o <= 1'b0;
		repeat (cycles) @(posedge clk_i);
		rxd_o <= 1'b1;
	endtask : hold_low
endmodule : uac_remote_node

// *** tb/uac_top_tb.sv ***
// Self-checking bench for the alternate control and status block
`timescale 1ns/1ns
module uac_top_tb;
	import uac_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, rxd, tick, txd, lin_rx, addr_det, auto_addr, multidrop, auto_dir, irq;
	logic [7:0] addr_match;
	logic [15:0] baud_div;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int n, ticks, seen, p;
	integer seed = 32'h627e;
	logic [31:0] rd, wr;
	logic err;

	always #5 clk = ~clk;

	uac_remote_node u_node (.clk_i(clk), .rxd_o(rxd), .tick_o(tick));

	uac_top u_dut (
		.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .RXD_I(rxd), .BIT_TICK_I(tick),
		.TXD_O(txd), .LIN_RX_ENABLE_O(lin_rx), .RS485_ADDR_DETECT_O(addr_det),
		.RS485_AUTO_ADDR_O(auto_addr), .RS485_MULTIDROP_O(multidrop),
		.RS485_AUTO_DIR_O(auto_dir), .ADDR_MATCH_O(addr_match),
		.BAUD_DIVIDER_O(baud_div), .IRQ_O(irq)
	);

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// Overflow test alone needs about 66000 cycles; the rest a few thousand
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			errors++;
			$display("ERROR %0t timeout", $time);
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [7:0] pattern(input logic [1:0] s);
		return 8'h01 << ((1 << s) - 1);
	endfunction : pattern

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, ALT_CSR_OFFSET, 32'h0000_0000);
		chk(rd, ALT_CSR_RESET);
		chk(32'(txd), 32'h0000_0001);
		$display("test reset done");

		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		chk(32'(err), 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({rd[31:1], err}, 32'h0000_0001);
		$display("test unmapped done");

		for (int i = 0; i < 6; i++) begin
			wr = $random(seed) & 32'hFFFB_FF7F;
			if (i == 0) begin
				wr[10:8] = 3'b101;
			end
			if (wr[9]) begin
				wr[8] = 1'b0;
			end
			apb(1'b1, FUNSEL_OFFSET, 32'h0000_0003);
			apb(1'b1, ALT_CSR_OFFSET, wr);
			apb(1'b0, ALT_CSR_OFFSET, 32'h0000_0000);
			chk(rd, wr & 32'hFF18_874F);
			repeat (2) @(posedge clk);
			chk(32'({addr_match, addr_det, auto_dir, auto_addr, multidrop}),
				32'({wr[31:24], wr[15], wr[10:8]}));
			apb(1'b1, FUNSEL_OFFSET, 32'h0000_0001);
			repeat (2) @(posedge clk);
			chk(32'({lin_rx, addr_det, auto_dir, auto_addr, multidrop}),
				32'({wr[6], 4'h0}));
		end
		$display("test rs485 and lin rx done");

		for (int l = 0; l < 16; l += 5) begin
			apb(1'b1, ALT_CSR_OFFSET, 32'h0000_0080 | l);
			seen = 0;
			ticks = 0;
			n = 0;
			while (n < 3000 && !(seen && txd === 1'b1)) begin
				@(posedge clk);
				n++;
				if (txd === 1'b0) begin
					seen = 1;
				end
				if (txd === 1'b0 && tick === 1'b1) begin
					ticks++;
				end
			end
			chk(ticks, l + 1);
			apb(1'b0, ALT_CSR_OFFSET, 32'h0000_0000);
			chk(rd & 32'h0000_0080, 32'h0000_0000);
		end
		$display("test lin break done");

		for (int s = 0; s < 4; s++) begin
			p = 8 + ($random(seed) & 15);
			apb(1'b1, IEN_OFFSET, 32'(s[0]) << AB_IRQ_EN_BIT);
			apb(1'b1, ALT_CSR_OFFSET, (32'(s) << SPAN_LSB) | (32'h0000_0001 << AB_EN_BIT));
			u_node.send_byte(pattern(s[1:0]), p);
			n = 0;
			do begin
				apb(1'b0, ALT_CSR_OFFSET, 32'h0000_0000);
				n++;
			end while (rd[AB_EN_BIT] !== 1'b0 && n < 50);
			chk(rd & 32'h0006_0000, 32'h0002_0000);
			chk(32'(baud_div >= p - 1 && baud_div <= p + 1), 32'h0000_0001);
			repeat (2) @(posedge clk);
			chk(32'(irq), 32'(s[0]));
			apb(1'b0, FSR_OFFSET, 32'h0000_0000);
			chk(rd & 32'h0000_0006, 32'h0000_0002);
			apb(1'b1, FSR_OFFSET, 32'h0000_0006);
			apb(1'b0, ALT_CSR_OFFSET, 32'h0000_0000);
			chk(rd & 32'h0002_0000, 32'h0000_0000);
			repeat (2) @(posedge clk);
			chk(32'(irq), 32'h0000_0000);
		end
		$display("test autobaud done");

		// Line stuck low: counter overflows, divider keeps the last detected rate
		apb(1'b1, ALT_CSR_OFFSET, 32'h0000_0001 << AB_EN_BIT);
		u_node.hold_low(65600);
		apb(1'b0, ALT_CSR_OFFSET, 32'h0000_0000);
		chk(rd & 32'h0006_0000, 32'h0002_0000);
		chk(32'(baud_div), 32'(p));
		apb(1'b0, FSR_OFFSET, 32'h0000_0000);
		chk(rd & 32'h0000_0006, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0001);
		apb(1'b1, FSR_OFFSET, 32'h0000_0006);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0000_0000);
		$display("test autobaud overflow done");
		end_sim();
	end
endmodule : uac_top_tb

// *** verilog/uac_pkg.sv ***
// Package with register map, field positions and constants of the alternate control block
package uac_pkg;
	localparam logic [7:0] ALT_CSR_OFFSET = 8'h2C;
	localparam logic [7:0] FUNSEL_OFFSET = 8'h30;
	localparam logic [7:0] FSR_OFFSET = 8'h1C;
	localparam logic [7:0] IEN_OFFSET = 8'h04;
	localparam logic [7:0] BAUD_OFFSET = 8'h24;
	localparam logic [31:0] ALT_CSR_RESET = 32'h0000_000C;
	localparam int ADDR_MATCH_LSB = 24;
	localparam int SPAN_LSB = 19;
	localparam int AB_EN_BIT = 18;
	localparam int AB_FLAG_BIT = 17;
	localparam int ADDR_DET_BIT = 15;
	localparam int AUTO_DIR_BIT = 10;
	localparam int AUTO_ADDR_BIT = 9;
	localparam int MULTIDROP_BIT = 8;
	localparam int LIN_TX_BIT = 7;
	localparam int LIN_RX_BIT = 6;
	localparam int AB_TIMEOUT_BIT = 2;
	localparam int AB_DONE_BIT = 1;
	localparam int AB_IRQ_EN_BIT = 18;
	localparam int CHANNEL_INDEX = 0;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	localparam logic [3:0] OVERSAMPLE = 4'h4;
	typedef enum logic [1:0] {FUN_UART, FUN_LIN, FUN_IRDA, FUN_RS485} uac_fun_t;
endpackage : uac_pkg

// *** verilog/uac_sync.sv ***
// Two flip-flop synchroniser for the serial receive pin
`timescale 1ns/1ns
module uac_sync (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic d_i,
	uac_sync_if.src out
);
	logic meta_reg;
	logic stable_reg;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_reg <= 1'b1;
			stable_reg <= 1'b1;
		end else begin
			meta_reg <= d_i;
			stable_reg <= meta_reg;
		end
	end
	assign out.rx = stable_reg;
endmodule : uac_sync

// *** verilog/uac_sync_if.sv ***
// Interface carrying the synchronised serial input between modules
`timescale 1ns/1ns
interface uac_sync_if;
	logic rx;
	modport src (output rx);
	modport dst (input rx);
endinterface : uac_sync_if

// *** verilog/uac_top.sv ***
// Alternate control and status logic for one serial channel
`timescale 1ns/1ns
module uac_top import uac_pkg::*; (
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic RXD_I,
	input wire logic BIT_TICK_I,
	output logic TXD_O,
	output logic LIN_RX_ENABLE_O,
	output logic RS485_ADDR_DETECT_O,
	output logic RS485_AUTO_ADDR_O,
	output logic RS485_MULTIDROP_O,
	output logic RS485_AUTO_DIR_O,
	output logic [7:0] ADDR_MATCH_O,
	output logic [15:0] BAUD_DIVIDER_O,
	output logic IRQ_O
);
	localparam bit HAS_RS485 = (CHANNEL_INDEX < 2);
	localparam bit HAS_LIN = (CHANNEL_INDEX < 3);
	// As wide as the divider: at span 0 a count that overflows could not be loaded anyway
	localparam int AB_CNT_W = 16;

	uac_sync_if rx_if ();
	uac_sync u_sync (
		.clk_i(CLK_SYS_I),
		.reset_n_i(RESET_N_I),
		.d_i(RXD_I),
		.out(rx_if)
	);

	typedef enum {AB_IDLE, AB_WAIT_START, AB_MEASURE} uac_ab_state_t;

	// Register state
	logic [7:0] addr_match_reg, addr_match_next;
	logic [1:0] span_reg, span_next;
	logic ab_en_reg, ab_en_next;
	logic ab_done_reg, ab_done_next;
	logic ab_timeout_reg, ab_timeout_next;
	logic addr_det_reg, addr_det_next;
	logic auto_dir_reg, auto_dir_next;
	logic auto_addr_reg, auto_addr_next;
	logic multidrop_reg, multidrop_next;
	logic lin_tx_reg, lin_tx_next;
	logic lin_rx_reg, lin_rx_next;
	logic [3:0] brk_len_reg, brk_len_next;
	logic [1:0] fun_reg, fun_next;
	logic ab_irq_en_reg, ab_irq_en_next;
	logic [15:0] baud_reg, baud_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic irq_reg, irq_next;
	logic txd_reg, txd_next;
	// Auto-baud measurement
	uac_ab_state_t ab_state_reg, ab_state_next;
	logic [AB_CNT_W-1:0] ab_cnt_reg, ab_cnt_next;
	logic rx_prev_reg, rx_prev_next;
	// Break transmitter
	logic [4:0] brk_cnt_reg, brk_cnt_next;
	logic brk_busy_reg, brk_busy_next;

	function automatic logic [2:0] span_shift(input logic [1:0] sel);
		case (sel)
			2'b00: span_shift = 3'd0;
			2'b01: span_shift = 3'd1;
			2'b10: span_shift = 3'd2;
			default: span_shift = 3'd3;
		endcase
	endfunction : span_shift

	function automatic logic [31:0] alt_word(input logic [7:0] am, input logic [1:0] sp,
			input logic en, input logic fl, input logic ad, input logic dir,
			input logic aa, input logic md, input logic tx, input logic rx,
			input logic [3:0] bl);
		alt_word = {am, 3'b000, sp, en, fl, 1'b0, ad, 4'b0000, dir, aa, md, tx, rx,
			2'b00, bl};
	endfunction : alt_word

	logic setup_ok;
	logic wr_en;
	logic rd_en;
	logic ab_finish;
	logic ab_overflow;
	logic brk_finish;
	logic ab_flag;
	logic rx_rise;
	logic rx_fall;
	logic [AB_CNT_W-1:0] ab_per_bit;

	assign ab_flag = ab_done_reg | ab_timeout_reg;
	assign rx_rise = rx_if.rx & ~rx_prev_reg;
	assign rx_fall = ~rx_if.rx & rx_prev_reg;

	// Auto-baud measurement machine
	always_comb begin
		ab_state_next = ab_state_reg;
		ab_cnt_next = ab_cnt_reg;
		rx_prev_next = rx_if.rx;
		ab_finish = 1'b0;
		ab_overflow = 1'b0;
		// Count spans from start bit to first rising edge, start bit included
		ab_per_bit = ab_cnt_reg >> span_shift(span_reg);
		case (ab_state_reg)
			AB_IDLE: begin
				if (ab_en_reg) begin
					ab_state_next = AB_WAIT_START;
				end
			end
			AB_WAIT_START: begin
				ab_cnt_next = '0;
				if (!ab_en_reg) begin
					ab_state_next = AB_IDLE;
				end else if (rx_fall) begin
					ab_state_next = AB_MEASURE;
					ab_cnt_next = AB_CNT_W'(1);
				end
			end
			AB_MEASURE: begin
				if (!ab_en_reg) begin
					ab_state_next = AB_IDLE;
				end else if (rx_rise) begin
					ab_finish = 1'b1;
					ab_state_next = AB_IDLE;
				end else if (&ab_cnt_reg) begin
					ab_overflow = 1'b1;
					ab_state_next = AB_IDLE;
				end else begin
					ab_cnt_next = ab_cnt_reg + AB_CNT_W'(1);
				end
			end
			default: ab_state_next = AB_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ab_state_reg <= AB_IDLE;
			ab_cnt_reg <= '0;
			rx_prev_reg <= 1'b1;
		end else begin
			ab_state_reg <= ab_state_next;
			ab_cnt_reg <= ab_cnt_next;
			rx_prev_reg <= rx_prev_next;
		end
	end

	// Break transmitter: holds the line low until the length-plus-one-th bit tick
	always_comb begin
		brk_busy_next = brk_busy_reg;
		brk_cnt_next = brk_cnt_reg;
		txd_next = 1'b1;
		brk_finish = 1'b0;
		if (!brk_busy_reg) begin
			if (lin_tx_reg && fun_reg == FUN_LIN) begin
				brk_busy_next = 1'b1;
				brk_cnt_next = {1'b0, brk_len_reg} + 5'd1;
				txd_next = 1'b0;
			end
		end else begin
			txd_next = 1'b0;
			if (BIT_TICK_I) begin
				if (brk_cnt_reg == 5'd1) begin
					brk_busy_next = 1'b0;
					brk_finish = 1'b1;
					txd_next = 1'b1;
				end
				brk_cnt_next = brk_cnt_reg - 5'd1;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			brk_busy_reg <= 1'b0;
			brk_cnt_reg <= '0;
			txd_reg <= 1'b1;
		end else begin
			brk_busy_reg <= brk_busy_next;
			brk_cnt_reg <= brk_cnt_next;
			txd_reg <= txd_next;
		end
	end

	// Register file and bus slave
	assign setup_ok = PSEL_I & PENABLE_I & pready_reg;
	assign wr_en = setup_ok & PWRITE_I;
	assign rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;

	always_comb begin
		addr_match_next = addr_match_reg;
		span_next = span_reg;
		ab_en_next = ab_en_reg;
		ab_done_next = ab_done_reg;
		ab_timeout_next = ab_timeout_reg;
		addr_det_next = addr_det_reg;
		auto_dir_next = auto_dir_reg;
		auto_addr_next = auto_addr_reg;
		multidrop_next = multidrop_reg;
		lin_tx_next = lin_tx_reg;
		lin_rx_next = lin_rx_reg;
		brk_len_next = brk_len_reg;
		fun_next = fun_reg;
		ab_irq_en_next = ab_irq_en_reg;
		baud_next = baud_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		// Answer one cycle after setup: access phase always sees pready high
		pready_next = PSEL_I & ~PENABLE_I;
		if (rd_en) begin
			case (PADDR_I)
				ALT_CSR_OFFSET: prdata_next = alt_word(addr_match_reg, span_reg, ab_en_reg,
					ab_flag, addr_det_reg, auto_dir_reg, auto_addr_reg, multidrop_reg,
					lin_tx_reg, lin_rx_reg, brk_len_reg);
				FUNSEL_OFFSET: prdata_next = {30'h0000_0000, fun_reg};
				FSR_OFFSET: prdata_next = 32'(ab_timeout_reg) << AB_TIMEOUT_BIT |
					32'(ab_done_reg) << AB_DONE_BIT;
				IEN_OFFSET: prdata_next = 32'(ab_irq_en_reg) << AB_IRQ_EN_BIT;
				BAUD_OFFSET: prdata_next = {16'h0000, baud_reg};
				default: prdata_next = 32'h0000_0000;
			endcase
		end
		if (PSEL_I & ~PENABLE_I) begin
			case (PADDR_I)
				ALT_CSR_OFFSET, FUNSEL_OFFSET, FSR_OFFSET, IEN_OFFSET, BAUD_OFFSET:
					pslverr_next = 1'b0;
				default: pslverr_next = 1'b1;
			endcase
		end
		if (wr_en) begin
			case (PADDR_I)
				ALT_CSR_OFFSET: begin
					if (HAS_RS485) begin
						addr_match_next = PWDATA_I[ADDR_MATCH_LSB +: 8];
						addr_det_next = PWDATA_I[ADDR_DET_BIT];
						auto_dir_next = PWDATA_I[AUTO_DIR_BIT];
						auto_addr_next = PWDATA_I[AUTO_ADDR_BIT];
						multidrop_next = PWDATA_I[MULTIDROP_BIT];
					end
					span_next = PWDATA_I[SPAN_LSB +: 2];
					ab_en_next = PWDATA_I[AB_EN_BIT];
					if (HAS_LIN) begin
						lin_tx_next = PWDATA_I[LIN_TX_BIT];
						lin_rx_next = PWDATA_I[LIN_RX_BIT];
						brk_len_next = PWDATA_I[3:0];
					end
				end
				FUNSEL_OFFSET: fun_next = PWDATA_I[1:0];
				FSR_OFFSET: begin
					if (PWDATA_I[AB_TIMEOUT_BIT]) begin
						ab_timeout_next = 1'b0;
					end
					if (PWDATA_I[AB_DONE_BIT]) begin
						ab_done_next = 1'b0;
					end
				end
				IEN_OFFSET: ab_irq_en_next = PWDATA_I[AB_IRQ_EN_BIT];
				BAUD_OFFSET: baud_next = PWDATA_I[15:0];
				default: ;
			endcase
		end
		// Hardware events win over a simultaneous software write
		if (ab_finish) begin
			ab_done_next = 1'b1;
			ab_en_next = 1'b0;
			baud_next = ab_per_bit[15:0];
		end
		if (ab_overflow) begin
			ab_timeout_next = 1'b1;
			ab_en_next = 1'b0;
		end
		if (brk_finish) begin
			lin_tx_next = 1'b0;
		end
		irq_next = (ab_done_next | ab_timeout_next) & ab_irq_en_next;
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			addr_match_reg <= ALT_CSR_RESET[31:24];
			span_reg <= ALT_CSR_RESET[20:19];
			ab_en_reg <= 1'b0;
			ab_done_reg <= 1'b0;
			ab_timeout_reg <= 1'b0;
			addr_det_reg <= 1'b0;
			auto_dir_reg <= 1'b0;
			auto_addr_reg <= 1'b0;
			multidrop_reg <= 1'b0;
			lin_tx_reg <= 1'b0;
			lin_rx_reg <= 1'b0;
			brk_len_reg <= ALT_CSR_RESET[3:0];
			fun_reg <= FUN_UART;
			ab_irq_en_reg <= 1'b0;
			baud_reg <= BAUD_RESET;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			addr_match_reg <= addr_match_next;
			span_reg <= span_next;
			ab_en_reg <= ab_en_next;
			ab_done_reg <= ab_done_next;
			ab_timeout_reg <= ab_timeout_next;
			addr_det_reg <= addr_det_next;
			auto_dir_reg <= auto_dir_next;
			auto_addr_reg <= auto_addr_next;
			multidrop_reg <= multidrop_next;
			lin_tx_reg <= lin_tx_next;
			lin_rx_reg <= lin_rx_next;
			brk_len_reg <= brk_len_next;
			fun_reg <= fun_next;
			ab_irq_en_reg <= ab_irq_en_next;
			baud_reg <= baud_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
		end
	end

	// Mode outputs are gated by the function selected in fun_reg; registered for clean pins
	logic rs485_sel;
	assign rs485_sel = (fun_reg == FUN_RS485);
	logic [4:0] mode_reg;
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			mode_reg <= '0;
		end else begin
			// Auto-address and multidrop are assumed exclusive by software
			mode_reg <= {lin_rx_reg & (fun_reg == FUN_LIN), addr_det_reg & rs485_sel,
				auto_addr_reg & rs485_sel, multidrop_reg & rs485_sel,
				auto_dir_reg & rs485_sel};
		end
	end

	assign PRDATA_O = prdata_reg;
	assign PREADY_O = pready_reg;
	assign PSLVERR_O = pslverr_reg;
	assign TXD_O = txd_reg;
	assign IRQ_O = irq_reg;
	assign LIN_RX_ENABLE_O = mode_reg[4];
	assign RS485_ADDR_DETECT_O = mode_reg[3];
	assign RS485_AUTO_ADDR_O = mode_reg[2];
	assign RS485_MULTIDROP_O = mode_reg[1];
	assign RS485_AUTO_DIR_O = mode_reg[0];
	assign ADDR_MATCH_O = addr_match_reg;
	assign BAUD_DIVIDER_O = baud_reg;

	property p_ab_clear;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		ab_finish |=> !ab_en_reg && ab_done_reg;
	endproperty
	a_ab_clear: assert property (p_ab_clear) else $error("enable not cleared");

	property p_irq;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		IRQ_O == (ab_flag && ab_irq_en_reg);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_timeout;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		ab_overflow |=> ab_timeout_reg && $stable(baud_reg);
	endproperty
	a_timeout: assert property (p_timeout) else $error("overflow handling wrong");

	property p_divider;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		ab_finish |=> baud_reg == $past(ab_per_bit);
	endproperty
	a_divider: assert property (p_divider) else $error("divider not loaded");

	property p_break_len;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		(!brk_busy_reg && brk_busy_next) |=> brk_cnt_reg == {1'b0, $past(brk_len_reg)} + 5'd1;
	endproperty
	a_break_len: assert property (p_break_len) else $error("break length wrong");

	property p_break_clear;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		brk_finish |=> !lin_tx_reg && TXD_O;
	endproperty
	a_break_clear: assert property (p_break_clear) else $error("break not ended");

	property p_break_low;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		brk_busy_reg |-> !TXD_O;
	endproperty
	a_break_low: assert property (p_break_low) else $error("line not low");

	property p_lin_rx;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		(lin_rx_reg && fun_reg == FUN_LIN) |=> LIN_RX_ENABLE_O;
	endproperty
	a_lin_rx: assert property (p_lin_rx) else $error("lin receive not enabled");

	property p_rs485;
		@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		(fun_reg != FUN_RS485) |=> !RS485_ADDR_DETECT_O && !RS485_AUTO_DIR_O;
	endproperty
	a_rs485: assert property (p_rs485) else $error("rs485 active outside mode");
endmodule : uac_top
